// *** common/pcs_pkg.sv ***
// constants shared by the coder compander select block
// assumes a 32-bit axi4-lite bus with byte addresses
package pcs_pkg;
	// register map
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_COUNT = 8'h08;
	// control fields
	localparam int CTRL_COMP_EN_BIT = 0;
	localparam logic CTRL_COMP_EN_RST = 1'h1;
	// status fields
	localparam int STAT_PCM_BIT = 0;
	localparam int STAT_FIRST_ONE_BIT = 1;
	localparam int STAT_FIRST_ZERO_BIT = 2;
	localparam int STAT_COMP_RESET_BIT = 3;
	localparam int STAT_PATH_ATT_BIT = 4;
	// count of companded channels
	localparam int COUNT_W = 16;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] RDATA_NONE = 32'h0000_0000;
	// register selection
	typedef enum logic [1:0] {
		PCS_SEL_NONE,
		PCS_SEL_CTRL,
		PCS_SEL_STATUS,
		PCS_SEL_COUNT
	} pcs_sel_e;
endpackage

// *** design/pcs_coder_top.sv ***
// digital control of a successive approximation coder:
// decision bit flop, first decision store, compander reset, path select
// assumes slot strobes come from logic on aclk; the comparator is a pin
`timescale 1ns/1ps
`default_nettype none
module pcs_coder_top (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// slot timing
	input wire logic decision_pulse,
	input wire logic first_slot_strobe,
	input wire logic second_slot_strobe,
	input wire logic coding_start_strobe,
	// comparator pin, high when signal exceeds ladder
	input wire logic signal_above_ladder,
	// decision results
	output logic result_high_q,
	output logic result_low_q,
	output logic pcm_upper_q,
	output logic pcm_lower_q,
	// first decision store
	output logic first_one_q,
	output logic first_zero_q,
	// compander
	output logic compander_reset_q,
	output logic path_amp_q,
	output logic path_att_q,
	// axi4-lite write address
	input wire logic awvalid,
	output logic awready_q,
	input wire logic [pcs_pkg::ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	// axi4-lite write data
	input wire logic wvalid,
	output logic wready_q,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid_q,
	input wire logic bready,
	output logic [1:0] bresp_q,
	// axi4-lite read address
	input wire logic arvalid,
	output logic arready_q,
	input wire logic [pcs_pkg::ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	// axi4-lite read data
	output logic rvalid_q,
	input wire logic rready,
	output logic [31:0] rdata_q,
	output logic [1:0] rresp_q
);
	// ----------------------------------------
	// register decode
	// ----------------------------------------
	function automatic pcs_pkg::pcs_sel_e reg_sel(input logic [pcs_pkg::ADDR_W-1:0] addr);
		if (addr == pcs_pkg::ADDR_CTRL) begin
			reg_sel = pcs_pkg::PCS_SEL_CTRL;
		end else if (addr == pcs_pkg::ADDR_STATUS) begin
			reg_sel = pcs_pkg::PCS_SEL_STATUS;
		end else if (addr == pcs_pkg::ADDR_COUNT) begin
			reg_sel = pcs_pkg::PCS_SEL_COUNT;
		end else begin
			reg_sel = pcs_pkg::PCS_SEL_NONE;
		end
	endfunction

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic above_meta_q;
	logic above_q;
	logic t1_q;
	logic t2_q;
	logic comp_en_q;
	logic [pcs_pkg::COUNT_W-1:0] comp_count_q;
	logic [pcs_pkg::ADDR_W-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic do_write;
	logic upper_term;
	logic lower_term;
	logic [31:0] status_word;
	pcs_pkg::pcs_sel_e wsel;
	pcs_pkg::pcs_sel_e rsel;

	// ----------------------------------------
	// comparator synchroniser
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			above_meta_q <= 1'b0;
			above_q <= 1'b0;
		end else begin
			above_meta_q <= signal_above_ladder;
			above_q <= above_meta_q;
		end
	end

	// ----------------------------------------
	// decision steering
	// ----------------------------------------
	pcs_decision_steer u_steer (
		.aclk(aclk),
		.aresetn(aresetn),
		.decision_pulse(decision_pulse),
		.signal_above(above_q),
		.result_high_q(result_high_q),
		.result_low_q(result_low_q)
	);

	// slot markers aligned with the result pulses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			t1_q <= 1'b0;
			t2_q <= 1'b0;
		end else begin
			t1_q <= decision_pulse & first_slot_strobe;
			t2_q <= decision_pulse & second_slot_strobe;
		end
	end

	// ----------------------------------------
	// decision bit flop
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pcm_upper_q <= 1'b0;
			pcm_lower_q <= 1'b1;
		end else if (result_high_q) begin
			pcm_upper_q <= 1'b1;
			pcm_lower_q <= 1'b0;
		end else if (result_low_q) begin
			pcm_upper_q <= 1'b0;
			pcm_lower_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// first decision store
	// ----------------------------------------
	// a capture coinciding with coding start wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			first_one_q <= 1'b0;
			first_zero_q <= 1'b0;
		end else if (t1_q && (result_high_q || result_low_q)) begin
			first_one_q <= result_high_q;
			first_zero_q <= result_low_q;
		end else if (coding_start_strobe) begin
			first_one_q <= 1'b0;
			first_zero_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// compander reset
	// ----------------------------------------
	assign upper_term = result_high_q & first_one_q & t2_q;
	assign lower_term = result_low_q & first_zero_q & t2_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			compander_reset_q <= 1'b0;
		end else begin
			compander_reset_q <= comp_en_q & (upper_term | lower_term);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			comp_count_q <= pcs_pkg::COUNT_RST;
		end else if (compander_reset_q) begin
			comp_count_q <= comp_count_q + 16'h0001;
		end
	end

	// ----------------------------------------
	// path select
	// ----------------------------------------
	pcs_path_select u_path (
		.aclk(aclk),
		.aresetn(aresetn),
		.coding_start_strobe(coding_start_strobe),
		.compander_reset(compander_reset_q),
		.path_amp_q(path_amp_q),
		.path_att_q(path_att_q)
	);

	// ----------------------------------------
	// axi4-lite write
	// ----------------------------------------
	assign do_write = !awready_q && !wready_q && !bvalid_q;
	assign wsel = reg_sel(aw_addr_q);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= pcs_pkg::RESP_OKAY;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else begin
			if (awvalid && awready_q) begin
				awready_q <= 1'b0;
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready_q) begin
				wready_q <= 1'b0;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
			if (do_write) begin
				bvalid_q <= 1'b1;
				bresp_q <= (wsel == pcs_pkg::PCS_SEL_NONE) ? pcs_pkg::RESP_SLVERR : pcs_pkg::RESP_OKAY;
			end else if (bvalid_q && bready) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	// control register, only byte lane 0 holds a field
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			comp_en_q <= pcs_pkg::CTRL_COMP_EN_RST;
		end else if (do_write && wsel == pcs_pkg::PCS_SEL_CTRL && w_strb_q[0]) begin
			comp_en_q <= w_data_q[pcs_pkg::CTRL_COMP_EN_BIT];
		end
	end

	// ----------------------------------------
	// axi4-lite read
	// ----------------------------------------
	assign rsel = reg_sel(araddr);

	always_comb begin
		status_word = pcs_pkg::RDATA_NONE;
		status_word[pcs_pkg::STAT_PCM_BIT] = pcm_upper_q;
		status_word[pcs_pkg::STAT_FIRST_ONE_BIT] = first_one_q;
		status_word[pcs_pkg::STAT_FIRST_ZERO_BIT] = first_zero_q;
		status_word[pcs_pkg::STAT_COMP_RESET_BIT] = compander_reset_q;
		status_word[pcs_pkg::STAT_PATH_ATT_BIT] = path_att_q;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= pcs_pkg::RDATA_NONE;
			rresp_q <= pcs_pkg::RESP_OKAY;
		end else if (arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rresp_q <= pcs_pkg::RESP_OKAY;
			if (rsel == pcs_pkg::PCS_SEL_CTRL) begin
				rdata_q <= {31'h0000_0000, comp_en_q};
			end else if (rsel == pcs_pkg::PCS_SEL_STATUS) begin
				rdata_q <= status_word;
			end else if (rsel == pcs_pkg::PCS_SEL_COUNT) begin
				rdata_q <= {16'h0000, comp_count_q};
			end else begin
				rdata_q <= pcs_pkg::RDATA_NONE;
				rresp_q <= pcs_pkg::RESP_SLVERR;
			end
		end else if (rvalid_q && rready) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_bit_follows_high: assert property (@(posedge aclk) disable iff (!aresetn)
		result_high_q |=> pcm_upper_q && !pcm_lower_q)
		else $error("high result did not set the bit flop");
	a_bit_steady: assert property (@(posedge aclk) disable iff (!aresetn)
		!result_high_q && !result_low_q |=> $stable(pcm_upper_q))
		else $error("bit flop changed without a result pulse");
	a_upper_term: assert property (@(posedge aclk) disable iff (!aresetn)
		comp_en_q && result_high_q && first_one_q && t2_q |=> compander_reset_q)
		else $error("leading 11 did not raise compander reset");
	a_lower_term: assert property (@(posedge aclk) disable iff (!aresetn)
		comp_en_q && result_low_q && first_zero_q && t2_q |=> compander_reset_q)
		else $error("leading 00 did not raise compander reset");
	a_reset_needs_slot: assert property (@(posedge aclk) disable iff (!aresetn)
		compander_reset_q |-> $past(t2_q))
		else $error("compander reset outside the second slot");
	a_mixed_no_reset: assert property (@(posedge aclk) disable iff (!aresetn)
		t2_q && ((result_high_q && !first_one_q) || (result_low_q && !first_zero_q))
		|=> !compander_reset_q)
		else $error("compander reset for a mixed leading pair");
	a_first_complement: assert property (@(posedge aclk) disable iff (!aresetn)
		!(first_one_q && first_zero_q))
		else $error("first decision indications both true");
	a_first_capture: assert property (@(posedge aclk) disable iff (!aresetn)
		t1_q && result_low_q |=> first_zero_q && !first_one_q)
		else $error("first zero decision not stored");
	a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		arvalid && arready_q |=> rvalid_q && !arready_q)
		else $error("read not answered in one cycle");
	c_upper_pair: cover property (@(posedge aclk) disable iff (!aresetn)
		upper_term && comp_en_q ##1 compander_reset_q ##1 path_att_q);
	c_lower_pair: cover property (@(posedge aclk) disable iff (!aresetn)
		lower_term && comp_en_q ##1 compander_reset_q);
	c_write_done: cover property (@(posedge aclk) disable iff (!aresetn)
		bvalid_q && bready);
endmodule
`default_nettype wire

// *** design/pcs_decision_steer.sv ***
// steers each decision pulse onto the high or low result output
// assumes decision_pulse is a one-cycle strobe on aclk
`timescale 1ns/1ps
`default_nettype none
module pcs_decision_steer (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// decision inputs
	input wire logic decision_pulse,
	input wire logic signal_above,
	// result pulses
	output logic result_high_q,
	output logic result_low_q
);
	// ----------------------------------------
	// steering
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result_high_q <= 1'b0;
			result_low_q <= 1'b0;
		end else begin
			result_high_q <= decision_pulse & signal_above;
			result_low_q <= decision_pulse & ~signal_above;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_low_only: assert property (@(posedge aclk) disable iff (!aresetn)
		decision_pulse && !signal_above |=> result_low_q && !result_high_q)
		else $error("ladder above signal must give only a low result");
	a_high_only: assert property (@(posedge aclk) disable iff (!aresetn)
		decision_pulse && signal_above |=> result_high_q && !result_low_q)
		else $error("signal above ladder must give only a high result");
	a_no_stray_result: assert property (@(posedge aclk) disable iff (!aresetn)
		!decision_pulse |=> !result_high_q && !result_low_q)
		else $error("result pulse without a decision pulse");
endmodule
`default_nettype wire

// *** design/pcs_path_select.sv ***
// compander select flop driving the complementary path pair
// assumes coding_start_strobe and compander_reset are on aclk
`timescale 1ns/1ps
`default_nettype none
module pcs_path_select (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control
	input wire logic coding_start_strobe,
	input wire logic compander_reset,
	// path select pair
	output logic path_amp_q,
	output logic path_att_q
);
	// ----------------------------------------
	// select flop
	// ----------------------------------------
	// compander reset wins over a coincident coding start
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			path_amp_q <= 1'b1;
			path_att_q <= 1'b0;
		end else if (compander_reset) begin
			path_amp_q <= 1'b0;
			path_att_q <= 1'b1;
		end else if (coding_start_strobe) begin
			path_amp_q <= 1'b1;
			path_att_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_select_complement: assert property (@(posedge aclk) disable iff (!aresetn)
		path_amp_q != path_att_q)
		else $error("path select lines are not complementary");
	a_reset_attenuates: assert property (@(posedge aclk) disable iff (!aresetn)
		compander_reset |=> path_att_q && !path_amp_q)
		else $error("compander reset did not select attenuated path");
	a_hold_attenuate: assert property (@(posedge aclk) disable iff (!aresetn)
		path_att_q && !coding_start_strobe |=> path_att_q)
		else $error("attenuated path dropped before coding start");
	a_start_amplifies: assert property (@(posedge aclk) disable iff (!aresetn)
		coding_start_strobe && !compander_reset |=> path_amp_q)
		else $error("coding start did not select amplified path");
	c_att_then_start: cover property (@(posedge aclk) disable iff (!aresetn)
		path_att_q ##1 coding_start_strobe ##1 path_amp_q);
endmodule
`default_nettype wire

// *** tb/pcs_slot_model.sv ***
// slot timing, ladder sequencer and comparator model for the coder control
// assumes go is a one-cycle request on aclk, given only while busy is low
`timescale 1ns/1ps
`default_nettype none
module pcs_slot_model (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// request
	input wire logic go,
	input wire logic bit_a,
	input wire logic bit_b,
	input wire logic [3:0] gap,
	output logic busy,
	// slot timing and comparator
	output logic decision_pulse,
	output logic first_slot_strobe,
	output logic second_slot_strobe,
	output logic coding_start_strobe,
	output logic signal_above_ladder
);
	logic [4:0] step_q;
	always @(posedge aclk) begin
		coding_start_strobe <= 1'b0;
		decision_pulse <= 1'b0;
		first_slot_strobe <= 1'b0;
		second_slot_strobe <= 1'b0;
		if (!aresetn) begin
			step_q <= 5'h00;
			busy <= 1'b0;
			signal_above_ladder <= 1'b0;
		end else if (!busy) begin
			// idle comparator wanders, no decision may rely on it
			signal_above_ladder <= ~signal_above_ladder;
			if (go) begin
				busy <= 1'b1;
				step_q <= 5'h00;
				coding_start_strobe <= 1'b1;
				signal_above_ladder <= bit_a;
			end
		end else begin
			step_q <= step_q + 5'h01;
			if (step_q == 5'h02) begin
				decision_pulse <= 1'b1;
				first_slot_strobe <= 1'b1;
			end
			if (step_q == 5'h03)
				signal_above_ladder <= bit_b;
			if (step_q == 5'h06 + {1'b0, gap}) begin
				decision_pulse <= 1'b1;
				second_slot_strobe <= 1'b1;
			end
			if (step_q == 5'h07 + {1'b0, gap})
				busy <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** tb/tb_pcs_coder_top.sv ***
// self-checking bench for the coder compander select block
// assumes the slot model drives the timing pins and the bench the axi4-lite bus
`timescale 1ns/1ps
`default_nettype none
module tb_pcs_coder_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic go = 1'b0, bit_a = 1'b0, bit_b = 1'b0, busy;
	logic [3:0] gap = 4'h0;
	logic dp, fs, ss, cs, sal;
	logic rh, rl, pu, pl, f1, f0, cr, pa, pt;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'hF;
	logic [31:0] rdata_q;
	logic [1:0] bresp_q, rresp_q;
	int miscompares = 0, samples_checked = 0, seed = 54;
	int n_hi = 0, n_lo = 0, n_cr = 0, exp_cnt = 0;
	logic en = 1'b1;
	logic [31:0] rd;
	logic [1:0] rs;
	always #5 aclk = ~aclk;
	pcs_slot_model i_pcs_slot_model (.aclk(aclk), .aresetn(aresetn), .go(go), .bit_a(bit_a), .bit_b(bit_b),
		.gap(gap), .busy(busy), .decision_pulse(dp), .first_slot_strobe(fs), .second_slot_strobe(ss),
		.coding_start_strobe(cs), .signal_above_ladder(sal));
	pcs_coder_top i_pcs_coder_top (.aclk(aclk), .aresetn(aresetn), .decision_pulse(dp),
		.first_slot_strobe(fs), .second_slot_strobe(ss), .coding_start_strobe(cs),
		.signal_above_ladder(sal), .result_high_q(rh), .result_low_q(rl), .pcm_upper_q(pu),
		.pcm_lower_q(pl), .first_one_q(f1), .first_zero_q(f0), .compander_reset_q(cr),
		.path_amp_q(pa), .path_att_q(pt), .awvalid(awvalid), .awready_q(awready_q), .awaddr(awaddr),
		.awprot(3'h0), .wvalid(wvalid), .wready_q(wready_q), .wdata(wdata), .wstrb(wstrb),
		.bvalid_q(bvalid_q), .bready(bready), .bresp_q(bresp_q), .arvalid(arvalid),
		.arready_q(arready_q), .araddr(araddr), .arprot(3'h0), .rvalid_q(rvalid_q), .rready(rready),
		.rdata_q(rdata_q), .rresp_q(rresp_q));
	//----------------------------------------
	// checking and closing
	//----------------------------------------
	task automatic final_report();
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic hang();
		miscompares++;
		final_report();
	endtask
	// attenuate region by code range
	function automatic logic att_range(input int code);
		return (code <= 15) || (code >= 48);
	endfunction
	//----------------------------------------
	// monitor
	//----------------------------------------
	always @(posedge aclk) begin
		if (aresetn) begin
			n_hi += rh;
			n_lo += rl;
			n_cr += cr;
			chk(pt, !pa);
			if (dp === 1'b1) begin
				chk(pa, 1'b1);
				chk(cr, 1'b0);
			end
		end
	end
	//----------------------------------------
	// bus and channel tasks
	//----------------------------------------
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awvalid && awready_q === 1'b1)
				awvalid <= 1'b0;
			if (wvalid && wready_q === 1'b1)
				wvalid <= 1'b0;
			if (bvalid_q === 1'b1) begin
				r = bresp_q;
				break;
			end
		end
		bready <= 1'b0;
		if (n == 50)
			hang();
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arvalid && arready_q === 1'b1)
				arvalid <= 1'b0;
			if (rvalid_q === 1'b1) begin
				d = rdata_q;
				r = rresp_q;
				break;
			end
		end
		rready <= 1'b0;
		if (n == 50)
			hang();
	endtask
	task automatic run_channel(input int code, input logic [3:0] g);
		int n, h0, l0, c0;
		logic ea, b1, b2;
		b1 = code[5];
		b2 = code[4];
		ea = att_range(code) && en;
		h0 = n_hi;
		l0 = n_lo;
		c0 = n_cr;
		@(posedge aclk);
		go <= 1'b1;
		bit_a <= b1;
		bit_b <= b2;
		gap <= g;
		@(posedge aclk);
		go <= 1'b0;
		// busy rises at this edge; look from the next one on
		@(posedge aclk);
		for (n = 0; n < 40 && busy !== 1'b0; n++)
			@(posedge aclk);
		if (n == 40)
			hang();
		repeat (6) @(posedge aclk);
		chk(n_hi - h0, int'(b1) + int'(b2));
		chk(n_lo - l0, 2 - b1 - b2);
		chk(pu, b2);
		chk(pl, !b2);
		chk(f1, b1);
		chk(f0, !b1);
		chk(n_cr - c0, ea);
		chk(pt, ea);
		exp_cnt += ea;
		$display("test code %0d done", code);
	endtask
	//----------------------------------------
	// main sequence
	//----------------------------------------
	int corner[6] = '{0, 15, 16, 47, 48, 63};
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({pu, pl, f1, f0, cr, pa, pt}, 7'b0100010);
		axi_rd(pcs_pkg::ADDR_CTRL, rd, rs);
		chk(rd, 32'h0000_0001);
		chk(rs, pcs_pkg::RESP_OKAY);
		$display("test reset done");
		foreach (corner[i])
			run_channel(corner[i], corner[i] % 4);
		for (int k = 0; k < 24; k++)
			run_channel($random(seed) & 63, $random(seed) & 3);
		axi_rd(pcs_pkg::ADDR_COUNT, rd, rs);
		chk(rd, exp_cnt);
		// write with lane 0 masked must leave the enable set
		wstrb <= 4'h0;
		axi_wr(pcs_pkg::ADDR_CTRL, 32'h0000_0000, rs);
		wstrb <= 4'hF;
		axi_rd(pcs_pkg::ADDR_CTRL, rd, rs);
		chk(rd, 32'h0000_0001);
		axi_wr(pcs_pkg::ADDR_CTRL, 32'h0000_0000, rs);
		chk(rs, pcs_pkg::RESP_OKAY);
		en = 1'b0;
		run_channel(0, 4'h1);
		axi_wr(pcs_pkg::ADDR_CTRL, 32'h0000_0001, rs);
		en = 1'b1;
		run_channel(63, 4'h2);
		axi_wr(pcs_pkg::ADDR_STATUS, 32'hFFFF_FFFF, rs);
		chk(rs, pcs_pkg::RESP_OKAY);
		axi_rd(pcs_pkg::ADDR_STATUS, rd, rs);
		chk(rd, 32'h0000_0013);
		axi_wr(8'h0C, 32'h0000_0001, rs);
		chk(rs, pcs_pkg::RESP_SLVERR);
		axi_rd(8'h0C, rd, rs);
		chk(rd, pcs_pkg::RDATA_NONE);
		chk(rs, pcs_pkg::RESP_SLVERR);
		$display("test registers done");
		final_report();
	end
endmodule
`default_nettype wire
